// [pvi_cfg.svh]
// timing constants for the press valve interlock
`ifndef PVI_CFG_SVH
`define PVI_CFG_SVH

// bridge time and clock period, both in nanoseconds
`define PVI_BRIDGE_TIME_NS 100000000
`define PVI_CLK_PERIOD_NS  4
// bridge length in scan clocks: 100 ms at 4 ns, fits a 32-bit counter
`define PVI_BRIDGE_CYCLES  (`PVI_BRIDGE_TIME_NS / `PVI_CLK_PERIOD_NS)

`endif

// [pvi_pkg.sv]
// types for the press valve interlock
package pvi_pkg;

  typedef enum logic [1:0]
  {
    PVI_BR_IDLE = 2'b00,
    PVI_BR_RUN  = 2'b01,
    PVI_BR_DONE = 2'b10
  } pvi_bridge_state_t;

endpackage

// [pvi_press_valve_interlock.sv]
// press valve interlock: permits, creep feed enable and valve drives
//
// Operation
// - valve_rest_permit is the AND of both safety valve and direction valve feedback contacts.
// - valve_rest_permit gates the foot pedal enable so no creep stroke starts unless the valves rest.
// - both safety valves are driven whenever creep down, rapid down or upward enable is active.
// - both rapid-speed valves come from one shared signal, driven only by the rapid down enable.
// - the direction valve is driven by any downward enable, creep or rapid.
// - creep_pressure_permit is the AND of left and right pressure evaluations.
// - rapid_pressure_permit is the OR of left and right pressure evaluations.
// - pressure_bridge is true while creep_request is present and the 100 ms bridge_timer runs.
// - pressure_permit is pressure_bridge OR creep_pressure_permit.
// - creep_request rises on setup mode, an absent guards permit or a CNC slow request.
// - creep down enable needs request, pressure, pedal, e-stop, guards closed, machine ok, no up, no BDC.
// - during creep down enable the safety, direction and CNC plunger-down outputs are driven.
// - machine_permit is motor on AND oil filter ok AND CNC ok.
`timescale 1ns/100ps
`include "pvi_cfg.svh"

module pvi_press_valve_interlock
#(
  parameter int unsigned BRIDGE_CYCLES = `PVI_BRIDGE_CYCLES
)
(
  input  wire logic clk_sys,
  input  wire logic rst_b,
  input  wire logic left_safety_valve_feedback,
  input  wire logic right_safety_valve_feedback,
  input  wire logic direction_valve_feedback,
  input  wire logic left_rapid_valve_button,
  input  wire logic right_rapid_valve_button,
  input  wire logic motor_on_feedback,
  input  wire logic oil_filter_ok,
  input  wire logic cnc_status_ok,
  input  wire logic setup_mode_selected,
  input  wire logic guards_permit,
  input  wire logic cnc_slow_request,
  input  wire logic foot_pedal_ok,
  input  wire logic estop_permit,
  input  wire logic guards_stop,
  input  wire logic cnc_up_request,
  input  wire logic cnc_bdc_reached,
  input  wire logic rapid_down_enable,
  input  wire logic up_enable,
  output logic      valve_rest_permit,
  output logic      machine_permit,
  output logic      creep_pressure_permit,
  output logic      rapid_pressure_permit,
  output logic      pressure_bridge,
  output logic      pressure_permit,
  output logic      creep_request,
  output logic      foot_pedal_enable,
  output logic      creep_down_enable,
  output logic      left_safety_valve,
  output logic      right_safety_valve,
  output logic      left_rapid_valve,
  output logic      right_rapid_valve,
  output logic      direction_valve,
  output logic      cnc_plunger_down
);

  localparam int N_IN = 18;
  // synchronisers reset to idle levels: a guards permit read as absent would
  // raise a false creep request and start the bridge timer right after reset
  localparam logic [N_IN-1:0] SYNC_IDLE = 18'h00100;

  // ==========================================================
  // input synchronisers
  // field contacts are asynchronous, so every input sees two flops
  logic [N_IN-1:0] sync1_r;
  logic [N_IN-1:0] sync2_r;
  logic [N_IN-1:0] raw_in;

  assign raw_in = {left_safety_valve_feedback, right_safety_valve_feedback, direction_valve_feedback,
                   left_rapid_valve_button, right_rapid_valve_button, motor_on_feedback, oil_filter_ok,
                   cnc_status_ok, setup_mode_selected, guards_permit, cnc_slow_request, foot_pedal_ok,
                   estop_permit, guards_stop, cnc_up_request, cnc_bdc_reached, rapid_down_enable,
                   up_enable};

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      sync1_r <= SYNC_IDLE;
      sync2_r <= SYNC_IDLE;
    end
    else
    begin
      sync1_r <= raw_in;
      sync2_r <= sync1_r;
    end
  end

  logic s_lsv, s_rsv, s_dv, s_lrb, s_rrb, s_mot, s_oil, s_cnc, s_setup, s_guard;
  logic s_slow, s_pedal, s_estop, s_gstop, s_up, s_bdc, s_rapid, s_upen;
  assign {s_lsv, s_rsv, s_dv, s_lrb, s_rrb, s_mot, s_oil, s_cnc, s_setup, s_guard,
          s_slow, s_pedal, s_estop, s_gstop, s_up, s_bdc, s_rapid, s_upen} = sync2_r;

  // ==========================================================
  // bridge timer
  pvi_pkg::pvi_bridge_state_t br_state_r;
  pvi_pkg::pvi_bridge_state_t br_state_nxt;
  logic [31:0]                br_cnt_r;
  logic [31:0]                br_cnt_nxt;
  logic                       creep_request_nxt;
  logic                       timer_running;

  assign creep_request_nxt = s_setup | ~s_guard | s_slow;

  // timer restarts on each creep request rise
  always_comb
  begin
    br_state_nxt = br_state_r;
    br_cnt_nxt   = br_cnt_r;
    case (br_state_r)
      pvi_pkg::PVI_BR_IDLE:
      begin
        br_cnt_nxt = '0;
        if (creep_request_nxt)
          br_state_nxt = pvi_pkg::PVI_BR_RUN;
      end
      pvi_pkg::PVI_BR_RUN:
      begin
        if (!creep_request_nxt)
          br_state_nxt = pvi_pkg::PVI_BR_IDLE;
        else if (br_cnt_r >= BRIDGE_CYCLES - 1)
          br_state_nxt = pvi_pkg::PVI_BR_DONE;
        else
          br_cnt_nxt = br_cnt_r + 32'h1;
      end
      pvi_pkg::PVI_BR_DONE:
      begin
        if (!creep_request_nxt)
          br_state_nxt = pvi_pkg::PVI_BR_IDLE;
      end
      default:
        br_state_nxt = pvi_pkg::PVI_BR_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      br_state_r <= pvi_pkg::PVI_BR_IDLE;
      br_cnt_r   <= '0;
    end
    else
    begin
      br_state_r <= br_state_nxt;
      br_cnt_r   <= br_cnt_nxt;
    end
  end

  assign timer_running = (br_state_nxt == pvi_pkg::PVI_BR_RUN);

  // ==========================================================
  // permits and enables, registered once per scan
  logic vrp_nxt, mp_nxt, cpp_nxt, rpp_nxt, pb_nxt, pp_nxt, fpe_nxt, cde_nxt;
  logic lsv_nxt, lrv_nxt, dv_nxt, cpd_nxt, rapid_shared;

  always_comb
  begin
    vrp_nxt = s_lsv & s_rsv & s_dv;
    mp_nxt  = s_mot & s_oil & s_cnc;
    cpp_nxt = s_lrb & s_rrb;
    rpp_nxt = s_lrb | s_rrb;
    pb_nxt  = creep_request_nxt & timer_running;
    pp_nxt  = pb_nxt | cpp_nxt;
    fpe_nxt = s_pedal & vrp_nxt;
    cde_nxt = creep_request_nxt & pp_nxt & fpe_nxt & s_estop & ~s_gstop & mp_nxt & ~s_up & ~s_bdc;
    lsv_nxt = cde_nxt | s_rapid | s_upen;
    rapid_shared = s_rapid;
    lrv_nxt = rapid_shared;
    dv_nxt  = cde_nxt | s_rapid;
    cpd_nxt = (cde_nxt | s_rapid) & fpe_nxt;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      valve_rest_permit     <= 1'b0;
      machine_permit        <= 1'b0;
      creep_pressure_permit <= 1'b0;
      rapid_pressure_permit <= 1'b0;
      pressure_bridge       <= 1'b0;
      pressure_permit       <= 1'b0;
      creep_request         <= 1'b0;
      foot_pedal_enable     <= 1'b0;
      creep_down_enable     <= 1'b0;
      left_safety_valve     <= 1'b0;
      right_safety_valve    <= 1'b0;
      left_rapid_valve      <= 1'b0;
      right_rapid_valve     <= 1'b0;
      direction_valve       <= 1'b0;
      cnc_plunger_down      <= 1'b0;
    end
    else
    begin
      valve_rest_permit     <= vrp_nxt;
      machine_permit        <= mp_nxt;
      creep_pressure_permit <= cpp_nxt;
      rapid_pressure_permit <= rpp_nxt;
      pressure_bridge       <= pb_nxt;
      pressure_permit       <= pp_nxt;
      creep_request         <= creep_request_nxt;
      foot_pedal_enable     <= fpe_nxt;
      creep_down_enable     <= cde_nxt;
      left_safety_valve     <= lsv_nxt;
      right_safety_valve    <= lsv_nxt;
      left_rapid_valve      <= lrv_nxt;
      right_rapid_valve     <= lrv_nxt;
      direction_valve       <= dv_nxt;
      cnc_plunger_down      <= cpd_nxt;
    end
  end

endmodule

// [pvi_field_model.sv]
// field side model: valve contacts, push buttons and cnc lines
`timescale 1ns/100ps
module pvi_field
(
  input  wire logic        clk_sys,
  input  wire logic [17:0] cmd,
  output logic      [17:0] pin = 18'h00200
);
  // contacts change one scan late; a clean single step, no bounce, is the only liberty taken
  always @(posedge clk_sys)
    pin <= cmd;
endmodule

// [pvi_interlock_sva.sv]
// concurrent checks on the press valve interlock ports
`timescale 1ns/100ps
module pvi_interlock_chk
(
  input wire logic clk_sys, rst_b,
  input wire logic left_safety_valve_feedback, right_safety_valve_feedback, direction_valve_feedback,
  input wire logic left_rapid_valve_button, right_rapid_valve_button, rapid_down_enable, up_enable,
  input wire logic valve_rest_permit, creep_pressure_permit, rapid_pressure_permit, pressure_bridge,
  input wire logic pressure_permit, creep_request, creep_down_enable, direction_valve,
  input wire logic left_safety_valve, right_safety_valve, left_rapid_valve, right_rapid_valve
);
  logic [2:0] live_r;
  logic [2:0] live_nxt;
  logic       ok;
  // inputs take three edges to reach outputs, so the pipe is flushed before checking
  always_comb live_nxt = (live_r == 3'h4) ? live_r : live_r + 3'h1;
  always_ff @(posedge clk_sys) live_r <= rst_b ? live_nxt : 3'h0;
  assign ok = (live_r == 3'h4);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // ==========================================
  // assertions
  rest_and_a: assert property (
    ok |-> valve_rest_permit == $past(left_safety_valve_feedback & right_safety_valve_feedback
      & direction_valve_feedback, 3)) else $error("valve rest permit wrong");
  creep_pres_a: assert property (
    ok |-> creep_pressure_permit == $past(left_rapid_valve_button & right_rapid_valve_button, 3))
    else $error("creep pressure permit wrong");
  rapid_pres_a: assert property (
    ok |-> rapid_pressure_permit == $past(left_rapid_valve_button | right_rapid_valve_button, 3))
    else $error("rapid pressure permit wrong");
  rapid_valve_a: assert property (
    ok |-> left_rapid_valve == $past(rapid_down_enable, 3) && right_rapid_valve == left_rapid_valve)
    else $error("rapid valves wrong");
  safety_valve_a: assert property (
    ok |-> left_safety_valve == (creep_down_enable | $past(rapid_down_enable | up_enable, 3))
      && right_safety_valve == left_safety_valve) else $error("safety valves wrong");
  dir_valve_a: assert property (
    ok |-> direction_valve == (creep_down_enable | $past(rapid_down_enable, 3)))
    else $error("direction valve wrong");
  perm_or_a: assert property (
    pressure_permit == (pressure_bridge | creep_pressure_permit)) else $error("pressure permit wrong");
  bridge_req_a: assert property (
    pressure_bridge |-> creep_request) else $error("bridge without creep request");
  cover property (creep_down_enable);
  cover property (left_rapid_valve);
  cover property ($fell(pressure_bridge) && creep_request);
endmodule
bind pvi_press_valve_interlock pvi_interlock_chk chk (.*);

// [testbench.sv]
// self-checking bench for the press valve interlock
`timescale 1ns/100ps
module testbench;
  localparam logic [17:0] BASE = 18'h01BFF;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [17:0] cmd = BASE;
  logic [14:0] q[$];
  int miscompares = 0;
  int checks_done = 0;
  event seen;
  wire left_safety_valve_feedback, right_safety_valve_feedback, direction_valve_feedback, left_rapid_valve_button,
    right_rapid_valve_button, motor_on_feedback, oil_filter_ok, cnc_status_ok, setup_mode_selected, guards_permit,
    cnc_slow_request, foot_pedal_ok, estop_permit, guards_stop, cnc_up_request, cnc_bdc_reached, rapid_down_enable,
    up_enable, valve_rest_permit, machine_permit, creep_pressure_permit, rapid_pressure_permit, pressure_bridge,
    pressure_permit, creep_request, foot_pedal_enable, creep_down_enable, left_safety_valve, right_safety_valve,
    left_rapid_valve, right_rapid_valve, direction_valve, cnc_plunger_down;
  wire [14:0] o = {valve_rest_permit, machine_permit, creep_pressure_permit, rapid_pressure_permit, pressure_bridge,
    pressure_permit, creep_request, foot_pedal_enable, creep_down_enable, left_safety_valve, right_safety_valve,
    left_rapid_valve, right_rapid_valve, direction_valve, cnc_plunger_down};
  initial forever #2 clk_sys = ~clk_sys;
  pvi_field fld (.clk_sys(clk_sys), .cmd(cmd), .pin({up_enable, rapid_down_enable, cnc_bdc_reached, cnc_up_request,
    guards_stop, estop_permit, foot_pedal_ok, cnc_slow_request, guards_permit, setup_mode_selected, cnc_status_ok,
    oil_filter_ok, motor_on_feedback, right_rapid_valve_button, left_rapid_valve_button, direction_valve_feedback,
    right_safety_valve_feedback, left_safety_valve_feedback}));
  pvi_press_valve_interlock #(.BRIDGE_CYCLES(10)) dut (.*);
  // ==========================================
  // expected outputs; br says whether the bridge time is still running
  function automatic logic [14:0] ex(logic [17:0] b, logic br);
    logic vr, mp, cp, cr, pb, fp, cd, dn;
    vr = &b[2:0];
    mp = &b[7:5];
    cp = &b[4:3];
    cr = b[8] | !b[9] | b[10];
    pb = cr & br;
    fp = b[11] & vr;
    cd = cr & (pb | cp) & fp & b[12] & !b[13] & mp & !b[14] & !b[15];
    dn = cd | b[16];
    return {vr, mp, cp, |b[4:3], pb, pb | cp, cr, fp, cd, {2{dn | b[17]}}, {2{b[16]}}, dn, dn & fp};
  endfunction
  task automatic cmp(logic [14:0] e, logic [14:0] g);
    checks_done++;
    if (g !== e)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  // a rest vector first drops the creep request so the bridge timer restarts
  task automatic apply(logic [17:0] b, logic br, int hold);
    @(posedge clk_sys) cmd <= 18'h00200;
    repeat (4) @(posedge clk_sys);
    cmd <= b;
    repeat (hold) @(posedge clk_sys);
    q.push_back(ex(b, br));
    @(negedge clk_sys) -> seen;
  endtask
  task automatic final_report;
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial forever
  begin
    @(seen);
    cmp(q.pop_front(), o);
  end
  initial
  begin
    #20000;
    miscompares++;
    final_report;
  end
  initial
  begin
    void'($urandom(32'h50304A26));
    repeat (8) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(negedge clk_sys);
    q.push_back(15'h0000);
    -> seen;
    @(negedge clk_sys);
    // still quiet at the first edge after release
    q.push_back(15'h0000);
    -> seen;
    for (int i = 0; i < 19; i++)
      apply((i < 18) ? BASE ^ (18'h1 << i) : BASE, 1'b1, 7);
    repeat (40) apply(18'($urandom), 1'b1, 7);
    apply(BASE & 18'h3FFE7, 1'b0, 30);
    @(negedge clk_sys);
    final_report;
  end
endmodule
